// >>> logic/uos_otg_regs.v
// Function
// - status bit 7 shows plug type, 1 for none or B cable, 0 for A plug.
// - status bit 5 is 1 only after line state unchanged for 1 ms.
// - status bit 3 follows the session-valid comparator.
// - status bit 2 follows the B-device session-end comparator.
// - status bit 0 follows the A-device bus-valid comparator.
// - unimplemented status and control bits read zero; writes to them do nothing.
// - status bits change only from hardware, software cannot write them.
// - with dual-role off, pull resistors follow host-role and port-enable settings.
// - control bit 6 switches the minus-line pull-up on and off while control bit 2 (dual-role) is set.
`timescale 1ns/10ps
`include "uos_defines.vh"
module uos_otg_regs #(
  parameter [`UOS_STABLE_CNT_W-1:0] STABLE_CYCLES = `UOS_STABLE_CYCLES
) (
  input  wire        MCLK_I,
  input  wire        RST_I,
  input  wire        CYC_I,
  input  wire        STB_I,
  input  wire        WE_I,
  input  wire [7:0]  ADR_I,
  input  wire [3:0]  SEL_I,
  input  wire [31:0] DAT_I,
  output wire [31:0] DAT_O,
  output wire        ACK_O,
  output wire        IRQ_O,
  input  wire        PLUG_TYPE_INDICATOR_I,
  input  wire        SE0_DETECT_I,
  input  wire        J_LEVEL_DETECT_I,
  input  wire        SESSION_VALID_I,
  input  wire        B_SESSION_END_I,
  input  wire        A_BUS_VALID_I,
  input  wire        HOST_ROLE_EN_I,
  input  wire        PORT_MODULE_EN_I,
  output wire        PLUS_LINE_PULLUP_EN_O,
  output wire        MINUS_LINE_PULLUP_EN_O,
  output wire        PLUS_LINE_PULLDOWN_EN_O,
  output wire        MINUS_LINE_PULLDOWN_EN_O,
  output wire        BUS_POWER_ON_O,
  output wire        DUAL_ROLE_FEATURES_EN_O,
  output wire        BUS_CHARGE_SELECT_O,
  output wire        BUS_DISCHARGE_EN_O
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [5:0] pins_s;

  uos_sync2 #(
    .W (6)
  ) u_sync (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .d_i   ({PLUG_TYPE_INDICATOR_I, SE0_DETECT_I, J_LEVEL_DETECT_I,
             SESSION_VALID_I, B_SESSION_END_I, A_BUS_VALID_I}),
    .q_o   (pins_s)
  );

  wire       plug_type_indicator = pins_s[5];
  wire [1:0] line_state          = pins_s[4:3];
  wire       session_valid_flag  = pins_s[2];
  wire       b_session_end_flag  = pins_s[1];
  wire       a_bus_valid_flag    = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // line stability timer

  reg [1:0]                   line_prev_q;
  reg [`UOS_STABLE_CNT_W-1:0] stable_cnt_q;
  reg                         line_stable_flag_q;

  wire line_moved  = (line_state != line_prev_q);
  wire window_done = (stable_cnt_q >= STABLE_CYCLES - 1'b1);

  // any change of the line state restarts the window
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      line_prev_q  <= 2'h0;
      stable_cnt_q <= {`UOS_STABLE_CNT_W{1'b0}};
    end else begin
      line_prev_q <= line_state;
      if (line_moved) begin
        stable_cnt_q <= {`UOS_STABLE_CNT_W{1'b0}};
      end else if (!window_done) begin
        stable_cnt_q <= stable_cnt_q + 1'b1;
      end
    end
  end

  // the counter parks at the window end, so the flag stays up while the line rests
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      line_stable_flag_q <= 1'b0;
    end else if (line_moved) begin
      line_stable_flag_q <= 1'b0;
    end else begin
      line_stable_flag_q <= window_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word, hardware driven only

  reg [7:0] status_q;
  reg [7:0] status_d;

  always @* begin
    status_d                      = 8'h00;
    status_d[`UOS_ST_PLUG_BIT]    = plug_type_indicator;
    status_d[`UOS_ST_STABLE_BIT]  = line_stable_flag_q;
    status_d[`UOS_ST_SESSVLD_BIT] = session_valid_flag;
    status_d[`UOS_ST_SESSEND_BIT] = b_session_end_flag;
    status_d[`UOS_ST_ABUSVLD_BIT] = a_bus_valid_flag;
  end

  // one register stage gives the read mux a clean source
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  // map, word aligned, low address bits ignored:
  //   status        read only, hardware driven
  //   control       read/write
  //   event status  read only, sticky change flags
  //   event clear   write only, ones clear
  //   event enable  read/write, gates the interrupt
  //   all registers live in byte lane 0
  // unmapped words answer with zero data

  reg        ack_q;
  reg [31:0] dat_q;
  reg [7:0]  control_q;
  reg [7:0]  evt_status_q;
  reg [7:0]  evt_enable_q;
  reg        irq_q;

  localparam [1:0] BUS_IDLE = 2'b01;
  localparam [1:0] BUS_ACK  = 2'b10;

  reg [1:0] bus_state_q;
  reg [1:0] bus_state_d;

  wire       req            = CYC_I & STB_I;
  wire [7:0] adr_word       = {ADR_I[7:2], 2'h0};
  wire       hit_control    = (adr_word == `UOS_OFS_CONTROL);
  wire       hit_evt_clear  = (adr_word == `UOS_OFS_EVT_CLEAR);
  wire       hit_evt_enable = (adr_word == `UOS_OFS_EVT_ENABLE);

  wire       wr_now         = req & ack_q & WE_I & SEL_I[0];
  wire       wr_ctl         = wr_now & hit_control;
  wire       wr_clr         = wr_now & hit_evt_clear;
  wire       wr_en          = wr_now & hit_evt_enable;

  reg [7:0] rd_byte;

  always @* begin
    case (adr_word)
      `UOS_OFS_STATUS:     rd_byte = status_q;
      `UOS_OFS_CONTROL:    rd_byte = control_q;
      `UOS_OFS_EVT_STATUS: rd_byte = evt_status_q;
      `UOS_OFS_EVT_ENABLE: rd_byte = evt_enable_q;
      default:             rd_byte = 8'h00;
    endcase
  end

  // a request still held after its ack is taken again; the master must drop it
  always @* begin
    case (bus_state_q)
      BUS_IDLE: begin
        if (req) begin
          bus_state_d = BUS_ACK;
        end else begin
          bus_state_d = BUS_IDLE;
        end
      end
      BUS_ACK: begin
        bus_state_d = BUS_IDLE;
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  // ack follows the taking edge; read data is latched at that edge
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_state_q <= BUS_IDLE;
      ack_q       <= 1'b0;
      dat_q       <= 32'h00000000;
    end else begin
      bus_state_q <= bus_state_d;
      ack_q       <= bus_state_d[1];
      if (bus_state_q[0] & req) begin
        dat_q <= {24'h000000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control storage

  // only byte lane 0 carries implemented bits
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      control_q <= `UOS_CONTROL_RST;
    end else if (wr_ctl) begin
      control_q <= DAT_I[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change events and interrupt

  // only implemented status positions raise events
  wire [7:0] evt_set      = (status_d ^ status_q) & `UOS_ST_IMPL_MASK;
  wire [7:0] evt_clr_mask = {8{wr_clr}} & DAT_I[7:0];
  wire [7:0] evt_next     = (evt_status_q & ~evt_clr_mask) | evt_set;
  wire       irq_d        = |(evt_status_q & evt_enable_q);

  // a change arriving with a clear is kept; irq lags the flags by one cycle
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      evt_status_q <= `UOS_EVT_RST;
      irq_q        <= 1'b0;
    end else begin
      evt_status_q <= evt_next;
      irq_q        <= irq_d;
    end
  end

  // enable bits of unimplemented positions stay zero
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      evt_enable_q <= `UOS_EVT_RST;
    end else if (wr_en) begin
      evt_enable_q <= DAT_I[7:0] & `UOS_ST_IMPL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pull resistor and bus power outputs

  // patterns with dual-role off, as {plus up, minus up, plus down, minus down}:
  // host role: both pull-downs, so an attaching device can be seen
  // device role: plus-line pull-up announces a full-speed device
  // module off: lines left to float
  localparam [3:0] PULL_HOST   = 4'h3;
  localparam [3:0] PULL_DEVICE = 4'h8;
  localparam [3:0] PULL_NONE   = 4'h0;

  reg [3:0] pull_d;
  reg [3:0] pull_q;
  reg [3:0] supply_q;

  always @* begin
    if (control_q[`UOS_CT_OTG_BIT]) begin
      pull_d = control_q[7:4];
    end else if (PORT_MODULE_EN_I & HOST_ROLE_EN_I) begin
      pull_d = PULL_HOST;
    end else if (PORT_MODULE_EN_I) begin
      pull_d = PULL_DEVICE;
    end else begin
      pull_d = PULL_NONE;
    end
  end

  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pull_q   <= 4'h0;
      supply_q <= 4'h0;
    end else begin
      pull_q   <= pull_d;
      supply_q <= control_q[3:0];
    end
  end

  // outputs come straight from the drive flops
  assign PLUS_LINE_PULLUP_EN_O    = pull_q[3];
  assign MINUS_LINE_PULLUP_EN_O   = pull_q[2];
  assign PLUS_LINE_PULLDOWN_EN_O  = pull_q[1];
  assign MINUS_LINE_PULLDOWN_EN_O = pull_q[0];
  assign BUS_POWER_ON_O           = supply_q[`UOS_CT_PWR_BIT];
  assign DUAL_ROLE_FEATURES_EN_O  = supply_q[`UOS_CT_OTG_BIT];
  assign BUS_CHARGE_SELECT_O      = supply_q[`UOS_CT_CHG_BIT];
  assign BUS_DISCHARGE_EN_O       = supply_q[`UOS_CT_DIS_BIT];

  assign DAT_O = dat_q;
  assign ACK_O = ack_q;
  assign IRQ_O = irq_q;

endmodule

// >>> shared/uos_defines.vh
`ifndef UOS_DEFINES_VH
`define UOS_DEFINES_VH

// register byte offsets
`define UOS_OFS_STATUS      8'h00
`define UOS_OFS_CONTROL     8'h04
`define UOS_OFS_EVT_STATUS  8'h08
`define UOS_OFS_EVT_CLEAR   8'h0c
`define UOS_OFS_EVT_ENABLE  8'h10

// status word field positions
`define UOS_ST_PLUG_BIT     7
`define UOS_ST_STABLE_BIT   5
`define UOS_ST_SESSVLD_BIT  3
`define UOS_ST_SESSEND_BIT  2
`define UOS_ST_ABUSVLD_BIT  0
`define UOS_ST_IMPL_MASK    8'had

// control word field positions
`define UOS_CT_DP_PU_BIT    7
`define UOS_CT_DM_PU_BIT    6
`define UOS_CT_DP_PD_BIT    5
`define UOS_CT_DM_PD_BIT    4
`define UOS_CT_PWR_BIT      3
`define UOS_CT_OTG_BIT      2
`define UOS_CT_CHG_BIT      1
`define UOS_CT_DIS_BIT      0

// reset values
`define UOS_CONTROL_RST     8'h00
`define UOS_EVT_RST         8'h00

// line stability window: 1 ms of 200 MHz clock cycles
`define UOS_STABLE_CYCLES   18'd200000
`define UOS_STABLE_CNT_W    18

`endif

// >>> logic/uos_sync2.v
`timescale 1ns/10ps
module uos_sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// >>> testbench/uos_phy_model.sv
`timescale 1ns/10ps
module uos_phy_model (
  input  wire       clk_i,
  input  wire [5:0] lvl_i,
  output reg  [5:0] pins_o
);
  // comparators and line receivers settle one cycle after the bus moves
  initial pins_o = 6'h20;
  always @(posedge clk_i) begin
    pins_o <= lvl_i;
  end
endmodule

// >>> testbench/uos_otg_regs_monitor.sv
`timescale 1ns/10ps
module uos_otg_regs_monitor (
  input wire        MCLK_I, RST_I, CYC_I, STB_I, WE_I, ACK_O, IRQ_O,
  input wire [7:0]  ADR_I,
  input wire [3:0]  SEL_I,
  input wire [31:0] DAT_I, DAT_O,
  input wire        PLUG_TYPE_INDICATOR_I, SESSION_VALID_I, B_SESSION_END_I, A_BUS_VALID_I,
  input wire        HOST_ROLE_EN_I, PORT_MODULE_EN_I, DUAL_ROLE_FEATURES_EN_O, BUS_POWER_ON_O,
  input wire        PLUS_LINE_PULLUP_EN_O, MINUS_LINE_PULLUP_EN_O,
  input wire        PLUS_LINE_PULLDOWN_EN_O, MINUS_LINE_PULLDOWN_EN_O
);
  wire [3:0] pulls = {PLUS_LINE_PULLUP_EN_O, MINUS_LINE_PULLUP_EN_O,
                      PLUS_LINE_PULLDOWN_EN_O, MINUS_LINE_PULLDOWN_EN_O};
  wire       wr    = ACK_O && WE_I && SEL_I[0];
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  chk_ack_delay: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
  chk_zero_bits:
    assert property (ACK_O && !WE_I |->
      (DAT_O & (ADR_I == 8'h00 ? 32'hffffff52 : 32'hffffff00)) == 0) else $error("bits set");
  chk_pin_report:
    assert property (ACK_O && !WE_I && ADR_I == 8'h00 && !$past(RST_I, 4) |->
      {DAT_O[7], DAT_O[3:2], DAT_O[0]} == $past({PLUG_TYPE_INDICATOR_I, SESSION_VALID_I,
      B_SESSION_END_I, A_BUS_VALID_I}, 4)) else $error("status differs from pins");
  chk_pull_map:
    assert property (!DUAL_ROLE_FEATURES_EN_O && !$past(DUAL_ROLE_FEATURES_EN_O) &&
      !$past(RST_I) |-> pulls == ($past(PORT_MODULE_EN_I) ?
      ($past(HOST_ROLE_EN_I) ? 4'h3 : 4'h8) : 4'h0)) else $error("pull map wrong");
  chk_ctrl_apply:
    assert property (wr && ADR_I == 8'h04 |-> ##2
      {BUS_POWER_ON_O, DUAL_ROLE_FEATURES_EN_O} == $past(DAT_I[3:2], 2)) else $error("ctrl");
  chk_minus_pullup:
    assert property (wr && ADR_I == 8'h04 && DAT_I[2] |-> ##2
      MINUS_LINE_PULLUP_EN_O == $past(DAT_I[6], 2)) else $error("minus pull-up wrong");
  chk_irq_mask:
    assert property (wr && ADR_I == 8'h10 && DAT_I[7:0] == 0 |-> ##2 !IRQ_O) else $error("irq");
  cover property (wr && ADR_I == 8'h04);
  cover property (ACK_O && !WE_I && ADR_I == 8'h00 && DAT_O[5]);
  cover property (IRQ_O);
endmodule
bind uos_otg_regs uos_otg_regs_monitor i_mon (.*);

// >>> testbench/uos_otg_regs_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module uos_otg_regs_bench;
  reg         mclk = 0, rst = 1, cyc = 0, we = 0, host = 0, port = 0;
  reg  [7:0]  adr = 0, c = 0;
  reg  [3:0]  sel = 0, s;
  reg  [31:0] wdat = 0, d, rd;
  reg  [5:0]  lvl = 6'h20;
  wire [31:0] rdat;
  wire [7:0]  outs;
  wire [5:0]  pin;
  wire        ack, irq;
  integer     failures = 0, check_count = 0, ncyc = 0, i;
  always #2.5 mclk = ~mclk;
  uos_phy_model i_phy (.clk_i(mclk), .lvl_i(lvl), .pins_o(pin));
  uos_otg_regs #(.STABLE_CYCLES(18'd20)) i_dut (
    .MCLK_I(mclk), .RST_I(rst), .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .IRQ_O(irq),
    .PLUG_TYPE_INDICATOR_I(pin[5]), .SE0_DETECT_I(pin[4]), .J_LEVEL_DETECT_I(pin[3]),
    .SESSION_VALID_I(pin[2]), .B_SESSION_END_I(pin[1]), .A_BUS_VALID_I(pin[0]),
    .HOST_ROLE_EN_I(host), .PORT_MODULE_EN_I(port),
    .PLUS_LINE_PULLUP_EN_O(outs[7]), .MINUS_LINE_PULLUP_EN_O(outs[6]),
    .PLUS_LINE_PULLDOWN_EN_O(outs[5]), .MINUS_LINE_PULLDOWN_EN_O(outs[4]),
    .BUS_POWER_ON_O(outs[3]), .DUAL_ROLE_FEATURES_EN_O(outs[2]),
    .BUS_CHARGE_SELECT_O(outs[1]), .BUS_DISCHARGE_EN_O(outs[0]));
  ////////////////////////////////////////////////////////////////
  function [31:0] exp_st(input stab);
    exp_st = {24'h0, lvl[5], 1'b0, stab, 1'b0, lvl[2:1], 1'b0, lvl[0]};
  endfunction
  task bus(input [7:0] a, input w, input [3:0] se, input [31:0] dw);
    begin
      @(posedge mclk);
      adr <= a;
      we <= w;
      sel <= se;
      wdat <= dw;
      cyc <= 1;
      // look at ack between edges, then act on the edge that samples it high
      @(negedge mclk);
      while (ack !== 1'b1) @(negedge mclk);
      @(posedge mclk);
      rd = rdat;
      cyc <= 0;
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    ncyc++;
    if (ncyc == 5000) begin
      failures++;
      $display("FAIL %0t timeout", $time);
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    rd = $urandom(32'h889c3067);
    repeat (10) @(posedge mclk);
    rst <= 0;
    bus(8'h04, 0, 4'hf, 0);
    `CHK(rd, 32'h0)
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      s = $urandom;
      if (i < 4) begin
        s[0] = 1;
        d[2] = 0;
      end
      bus(8'h04, 1, s, d);
      if (s[0]) c = d[7:0];
      host <= i[0];
      port <= i[1];
      bus(8'h04, 0, 4'hf, 0);
      `CHK(rd, {24'h0, c})
      repeat (2) @(posedge mclk);
      `CHK(outs, c[2] ? c : {i[1] ? (i[0] ? 4'h3 : 4'h8) : 4'h0, c[3:0]})
    end
    for (i = 0; i < 6; i++) begin
      lvl <= ($urandom & 6'h37) | (~lvl & 6'h08);
      // let the pins pass the receivers, the synchroniser and the status stage
      repeat (6) @(posedge mclk);
      bus(8'h00, 1, 4'hf, 32'hffff);
      bus(8'h00, 0, 4'hf, 0);
      `CHK(rd, exp_st(0))
      repeat (30) @(posedge mclk);
      bus(8'h00, 0, 4'hf, 0);
      `CHK(rd, exp_st(1))
    end
    `CHK(irq, 1'b0)
    bus(8'h10, 1, 4'h1, 32'had);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1)
    bus(8'h10, 1, 4'h1, 0);
    bus(8'h0c, 1, 4'h1, 32'hff);
    bus(8'h08, 0, 4'hf, 0);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    bus(8'h10, 1, 4'h1, 32'had);
    lvl <= lvl ^ 6'h20;
    repeat (8) @(posedge mclk);
    `CHK(irq, 1'b1)
    bus(8'h08, 0, 4'hf, 0);
    `CHK(rd, 32'h80)
    bus(8'h14, 0, 4'hf, 0);
    `CHK(rd, 32'h0)
    wrap_up;
  end
endmodule
